//--- logic/scr_regs.svh
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH

// Readback control register and its fields
`define SCR_RBCTL_ADDR 7'h34
`define SCR_RBCTL_RST 9'h000
`define SCR_RB_EN_BIT 4
`define SCR_RB_CONT_BIT 3
// Status registers for non-continuous readback, index 0..6
`define SCR_STAT_BASE 7'h38
`define SCR_STAT_NUM 3'h7
// Two-wire device addresses, chip select low or high
`define SCR_DEV_ADDR0 7'h1A
`define SCR_DEV_ADDR1 7'h1B
// Frame geometry, in serial clocks
`define SCR_W3_BITS 5'h10
`define SCR_W3_RD_FIRST 5'h08
`define SCR_W2_BITS 5'h1B
`define SCR_W2_RD_FIRST 5'h12
`define SCR_W2_ACK_A 5'h08
`define SCR_W2_ACK_B 5'h11
`define SCR_W2_ACK_C 5'h1A
`define SCR_BYTE_BITS 5'h08
// Timing: system clock period and host serial clock quarter period
`define SCR_CLK_NS 100
`define SCR_QTR_NS 800
`define SCR_QTR_CYC ((`SCR_QTR_NS + `SCR_CLK_NS - 1) / `SCR_CLK_NS)

`endif

//--- logic/scr_pkg.sv
package scr_pkg;

  typedef enum logic [1:0] {DEV_IDLE, DEV_RECV, DEV_ACK, DEV_HOLD} scr_dev_fsm_t;
  typedef enum logic [1:0] {HST_IDLE, HST_START, HST_BITS, HST_STOP} scr_hst_fsm_t;

  typedef struct packed {
    scr_dev_fsm_t fsm;
    logic         sclk_q;
    logic         serial_data_in_q;
    logic         cs_q;
    logic [4:0]   cnt;
    logic [1:0]   byte_idx;
    logic [15:0]  sh;
    logic         ack_on;
    logic         sdo_on;
    logic         sdo_bit;
    logic [7:0]   rb;
    logic [8:0]   rbctl;
    logic         wr_stb;
    logic [6:0]   wr_addr;
    logic [8:0]   wr_data;
  } scr_dev_st_t;

  typedef struct packed {
    scr_hst_fsm_t fsm;
    logic         tw;
    logic [7:0]   div;
    logic [1:0]   qtr;
    logic [4:0]   bit_no;
    logic [26:0]  tx;
    logic [7:0]   rd;
    logic         nack;
    logic         done;
    logic         sclk;
    logic         cs_n;
    logic         sd_o;
    logic         sd_oe_n;
  } scr_hst_st_t;

endpackage

//--- logic/scr_link_if.sv
`timescale 1ns/1ps
interface scr_link_if;
  logic sclk;
  logic chip_select_n;
  logic host_sd_o;
  logic host_sd_oe_n;
  logic dev_sd_o;
  logic dev_sd_oe_n;
  logic dev_sdo_o;
  logic dev_sdo_oe_n;
  logic serial_data_in;
  logic serial_data_out;

  // Wired-AND data line; a released driver reads as pulled high
  assign serial_data_in  = (host_sd_oe_n | host_sd_o) & (dev_sd_oe_n | dev_sd_o);
  assign serial_data_out = dev_sdo_oe_n | dev_sdo_o;

  modport dev (input sclk, chip_select_n, serial_data_in,
               output dev_sd_o, dev_sd_oe_n, dev_sdo_o, dev_sdo_oe_n);
  modport host (output sclk, chip_select_n, host_sd_o, host_sd_oe_n,
                input serial_data_in, serial_data_out);
endinterface

//--- logic/scr_sync.sv
`timescale 1ns/1ps
module scr_sync #(
  parameter int W = 1
) (
  // System
  input  wire logic         CLK_SYS,
  input  wire logic         RST_B,
  // Asynchronous in, synchronised out
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } scr_sync_st_t;

  scr_sync_st_t r;
  scr_sync_st_t n;

  always_comb begin
    n      = r;
    n.meta = D;
    n.q    = r.meta;
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign Q = r.q;
endmodule // scr_sync

//--- logic/scr_device.sv
// Overview of operation
// R1: Mode pin low selects software control
// R2: Variant pin low two-wire, high three-wire
// R3: Three-wire samples data on clock rise
// R4: Write word: 7-bit address, 9-bit data
// R5: Chip-select rising edge commits the word
// R6: Readback only while enable bit 4 set
// R7: Continuous readback returns byte in last eight
// R8: Three-bit select picks returned status register
// R9: Bit 3 continuous; else addressed register returned
// R10: Data output released while chip select high
// R11: Data fall with clock high starts
// R12: Receive seven-bit address plus R/W, MSB first
// R13: Matching address acknowledged by pulling data low
// R14: Mismatched address returns to idle
// R15: Two control bytes, each acknowledged
// R16: Data rise with clock high stops
// R17: Out-of-sequence condition drops to idle; a start out of sequence restarts address receive instead
// R18: Chip-select pin picks the device address
// R19: Two-wire supports both readback methods
// R20: Three-wire word sent MSB first, address first
// R21: Two-wire commits only after second byte acknowledged
`timescale 1ns/1ps
`include "scr_regs.svh"
module scr_device import scr_pkg::*; (
  // System
  input  wire logic        CLK_SYS,
  input  wire logic        RST_B,
  // Mode straps
  input  wire logic        CONTROL_MODE_SELECT_PIN,
  input  wire logic        BUS_VARIANT_SELECT_PIN,
  // Status bytes, register n at [8n+7:8n]
  input  wire logic [55:0] STATUS_BYTES,
  // Register write port
  output logic             REG_WR_STB,
  output logic [6:0]       REG_WR_ADDR,
  output logic [8:0]       REG_WR_DATA,
  output logic [8:0]       READBACK_CONTROL,
  // Serial link
  scr_link_if.dev          LINK
);
  scr_dev_st_t r;
  scr_dev_st_t n;
  logic [4:0]  pins_s;
  logic        s_hw;
  logic        s_var;
  logic        s_cs;
  logic        s_sclk;
  logic        s_serial_data_in;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_rise;
  logic        start_c;
  logic        stop_c;
  logic        rb_en;
  logic [6:0]  own_addr;

  scr_sync #(.W(5)) u_sync (
    .CLK_SYS (CLK_SYS),
    .RST_B   (RST_B),
    .D       ({CONTROL_MODE_SELECT_PIN, BUS_VARIANT_SELECT_PIN,
               LINK.chip_select_n, LINK.sclk, LINK.serial_data_in}),
    .Q       (pins_s)
  );

  assign {s_hw, s_var, s_cs, s_sclk, s_serial_data_in} = pins_s;
  assign sclk_rise = s_sclk & ~r.sclk_q;
  assign sclk_fall = ~s_sclk & r.sclk_q;
  assign cs_rise   = s_cs & ~r.cs_q;
  // R11: start detect
  assign start_c   = s_sclk & r.sclk_q & ~s_serial_data_in & r.serial_data_in_q;
  // R16: stop detect
  assign stop_c    = s_sclk & r.sclk_q & s_serial_data_in & ~r.serial_data_in_q;
  // R6: readback gate
  assign rb_en     = r.rbctl[`SCR_RB_EN_BIT];
  // R18: address strap
  assign own_addr  = s_cs ? `SCR_DEV_ADDR1 : `SCR_DEV_ADDR0;

  // Status byte for a readback; out-of-range selections return zero
  function automatic logic [7:0] rb_pick(logic [8:0] ctl, logic [6:0] addr,
                                         logic [55:0] st);
    logic [6:0] idx;
    begin
      // R9: continuous uses select, otherwise the written address
      idx = addr - `SCR_STAT_BASE;
      if (ctl[`SCR_RB_CONT_BIT]) begin
        // R8: select field
        idx = {4'h0, ctl[2:0]};
      end
      rb_pick = 8'h00;
      if (idx < {4'h0, `SCR_STAT_NUM}) begin
        rb_pick = st[{idx[2:0], 3'h0} +: 8];
      end
    end
  endfunction

  // Hands the finished word to the register port
  function automatic scr_dev_st_t commit(scr_dev_st_t s);
    scr_dev_st_t o;
    begin
      o         = s;
      o.wr_stb  = 1'h1;
      // R4: address then data
      o.wr_addr = s.sh[15:9];
      o.wr_data = s.sh[8:0];
      if (s.sh[15:9] == `SCR_RBCTL_ADDR) begin
        o.rbctl = s.sh[8:0];
      end
      commit = o;
    end
  endfunction

  always_comb begin
    n        = r;
    n.wr_stb = 1'h0;
    n.sclk_q = s_sclk;
    n.serial_data_in_q = s_serial_data_in;
    n.cs_q   = s_cs;
    // R1: hardware control ignores the link
    if (s_hw) begin
      n.fsm    = DEV_IDLE;
      n.cnt    = 5'h00;
      n.ack_on = 1'h0;
      n.sdo_on = 1'h0;
    // R2: three-wire variant
    end else if (s_var) begin
      n.fsm    = DEV_IDLE;
      n.ack_on = 1'h0;
      if (s_cs) begin
        // R10: release data output
        n.cnt    = 5'h00;
        n.sdo_on = 1'h0;
        // R5: commit on chip-select rise, full words only
        if (cs_rise && r.cnt == `SCR_W3_BITS) begin
          n = commit(n);
        end
      end else if (sclk_rise) begin
        // R3: sample on rising clock
        // R20: MSB first shift
        n.sh = {r.sh[14:0], s_serial_data_in};
        if (r.cnt <= `SCR_W3_BITS) begin
          n.cnt = r.cnt + 5'h01;
        end
      end else if (sclk_fall) begin
        // R7: drive status byte over the last eight bits
        if (r.cnt == `SCR_W3_RD_FIRST && rb_en) begin
          n.rb      = rb_pick(r.rbctl, r.sh[7:1], STATUS_BYTES);
          n.sdo_on  = 1'h1;
          n.sdo_bit = n.rb[7];
        end else if (r.cnt > `SCR_W3_RD_FIRST && r.cnt < `SCR_W3_BITS) begin
          n.rb      = {r.rb[6:0], 1'h0};
          n.sdo_bit = r.rb[6];
        end
      end
    end else if (start_c) begin
      // R11: any start begins a fresh address
      n.fsm      = DEV_RECV;
      n.cnt      = 5'h00;
      n.byte_idx = 2'h0;
      n.ack_on   = 1'h0;
      n.sdo_on   = 1'h0;
    end else if (stop_c) begin
      // R16: stop ends the transfer
      // R17: a stop out of sequence also lands here
      n.fsm    = DEV_IDLE;
      n.ack_on = 1'h0;
      n.sdo_on = 1'h0;
    end else begin
      case (r.fsm)
        DEV_RECV: begin
          if (sclk_rise && r.cnt < `SCR_BYTE_BITS) begin
            // R12: MSB first
            n.sh  = {r.sh[14:0], s_serial_data_in};
            n.cnt = r.cnt + 5'h01;
          end else if (sclk_fall && r.cnt == `SCR_BYTE_BITS) begin
            n.sdo_on = 1'h0;
            if (r.byte_idx == 2'h0 && (r.sh[7:1] != own_addr || r.sh[0])) begin
              // R14: not ours, wait for next start
              n.fsm = DEV_IDLE;
            end else begin
              // R13: acknowledge address
              // R15: acknowledge each control byte
              n.ack_on = 1'h1;
              n.fsm    = DEV_ACK;
            end
          end else if (sclk_fall && r.sdo_on) begin
            n.rb      = {r.rb[6:0], 1'h0};
            n.sdo_bit = r.rb[6];
          end
        end
        DEV_ACK: begin
          if (sclk_fall) begin
            n.ack_on = 1'h0;
            n.cnt    = 5'h00;
            if (r.byte_idx == 2'h2) begin
              // R21: commit only after last acknowledge
              n     = commit(n);
              n.fsm = DEV_HOLD;
            end else begin
              n.byte_idx = r.byte_idx + 2'h1;
              n.fsm      = DEV_RECV;
              // R19: readback rides on the second data byte
              if (r.byte_idx == 2'h1 && rb_en) begin
                n.rb      = rb_pick(r.rbctl, r.sh[7:1], STATUS_BYTES);
                n.sdo_on  = 1'h1;
                n.sdo_bit = n.rb[7];
              end
            end
          end
        end
        default: begin
          n.fsm = r.fsm;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      r       <= '0;
      r.rbctl <= `SCR_RBCTL_RST;
    end else begin
      r <= n;
    end
  end

  // Ack is open drain; output enable low means driving
  assign LINK.dev_sd_o     = 1'h0;
  assign LINK.dev_sd_oe_n  = ~r.ack_on;
  assign LINK.dev_sdo_o    = r.sdo_bit;
  assign LINK.dev_sdo_oe_n = ~r.sdo_on;
  assign REG_WR_STB        = r.wr_stb;
  assign REG_WR_ADDR       = r.wr_addr;
  assign REG_WR_DATA       = r.wr_data;
  assign READBACK_CONTROL  = r.rbctl;
endmodule // scr_device

//--- logic/scr_host.sv
`timescale 1ns/1ps
`include "scr_regs.svh"
module scr_host import scr_pkg::*; #(
  parameter int QTR_CYC = `SCR_QTR_CYC
) (
  // System
  input  wire logic       CLK_SYS,
  input  wire logic       RST_B,
  // Link set-up
  input  wire logic       TWO_WIRE_SEL,
  input  wire logic       ADDR_SEL,
  // Command
  input  wire logic       CMD_VALID,
  input  wire logic [6:0] CMD_ADDR,
  input  wire logic [8:0] CMD_DATA,
  output logic            CMD_READY,
  // Result
  output logic            DONE,
  output logic            NACK,
  output logic [7:0]      RD_DATA,
  // Serial link
  scr_link_if.host        LINK
);
  scr_hst_st_t r;
  scr_hst_st_t n;
  logic        s_serial_data_in;
  logic        s_sdo;
  logic        tick;
  logic        is_ack;
  logic        in_rd;
  logic [4:0]  last_bit;
  logic [4:0]  rd_first;

  scr_sync #(.W(2)) u_sync (
    .CLK_SYS (CLK_SYS),
    .RST_B   (RST_B),
    .D       ({LINK.serial_data_in, LINK.serial_data_out}),
    .Q       ({s_serial_data_in, s_sdo})
  );

  assign tick     = (r.div == 8'(QTR_CYC - 1));
  assign last_bit = r.tw ? `SCR_W2_BITS - 5'h01 : `SCR_W3_BITS - 5'h01;
  assign rd_first = r.tw ? `SCR_W2_RD_FIRST : `SCR_W3_RD_FIRST;
  assign in_rd    = r.bit_no >= rd_first && r.bit_no < rd_first + `SCR_BYTE_BITS;
  assign is_ack   = r.tw && (r.bit_no == `SCR_W2_ACK_A || r.bit_no == `SCR_W2_ACK_B
                             || r.bit_no == `SCR_W2_ACK_C);

  always_comb begin
    n      = r;
    n.done = 1'h0;
    n.div  = tick ? 8'h00 : r.div + 8'h01;
    case (r.fsm)
      HST_IDLE: begin
        n.div     = 8'h00;
        n.tw      = TWO_WIRE_SEL;
        n.sclk    = TWO_WIRE_SEL;
        n.cs_n    = TWO_WIRE_SEL ? ADDR_SEL : 1'h1;
        n.sd_o    = 1'h1;
        n.sd_oe_n = 1'h1;
        if (CMD_VALID) begin
          n.fsm    = HST_START;
          n.bit_no = 5'h00;
          n.qtr    = 2'h0;
          n.nack   = 1'h0;
          n.rd     = 8'h00;
          // Ack slots are ones, so the open-drain driver lets go there
          // R4 R12 R15 R20: frame word, MSB first
          n.tx     = TWO_WIRE_SEL ?
                     {(ADDR_SEL ? `SCR_DEV_ADDR1 : `SCR_DEV_ADDR0), 1'h0, 1'h1,
                      CMD_ADDR, CMD_DATA[8], 1'h1, CMD_DATA[7:0], 1'h1} :
                     {CMD_ADDR, CMD_DATA, 11'h000};
          // R11: start under high clock
          if (TWO_WIRE_SEL) begin
            n.sd_o    = 1'h0;
            n.sd_oe_n = 1'h0;
          end else begin
            n.cs_n    = 1'h0;
          end
        end
      end
      HST_START: begin
        if (tick) begin
          n.fsm     = HST_BITS;
          n.sclk    = 1'h0;
          n.sd_o    = r.tw ? 1'h0 : r.tx[26];
          n.sd_oe_n = r.tw ? r.tx[26] : 1'h0;
        end
      end
      HST_BITS: begin
        if (tick) begin
          n.qtr = r.qtr + 2'h1;
          case (r.qtr)
            2'h0: begin
              n.sclk = 1'h1;
            end
            2'h1: begin
              if (is_ack && s_serial_data_in) begin
                n.nack = 1'h1;
              end
              if (in_rd) begin
                n.rd = {r.rd[6:0], s_sdo};
              end
            end
            2'h2: begin
              n.sclk = 1'h0;
            end
            default: begin
              if (r.bit_no == last_bit) begin
                n.fsm     = HST_STOP;
                n.sd_o    = 1'h0;
                n.sd_oe_n = ~r.tw;
              end else begin
                n.bit_no  = r.bit_no + 5'h01;
                n.tx      = {r.tx[25:0], 1'h0};
                n.sd_o    = r.tw ? 1'h0 : r.tx[25];
                n.sd_oe_n = r.tw ? r.tx[25] : 1'h0;
              end
            end
          endcase
        end
      end
      default: begin
        // Stop: three-wire raises chip select, two-wire raises data under high clock
        // R10 R16: frame closed only here
        if (tick) begin
          n.qtr = r.qtr + 2'h1;
          if (!r.tw || r.qtr == 2'h2) begin
            n.fsm     = HST_IDLE;
            n.done    = 1'h1;
            n.cs_n    = r.tw ? r.cs_n : 1'h1;
            n.sd_oe_n = 1'h1;
          end else if (r.qtr == 2'h1) begin
            n.sclk = 1'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      r         <= '0;
      r.cs_n    <= 1'h1;
      r.sd_o    <= 1'h1;
      r.sd_oe_n <= 1'h1;
    end else begin
      r <= n;
    end
  end

  assign CMD_READY          = (r.fsm == HST_IDLE);
  assign DONE               = r.done;
  assign NACK               = r.nack;
  assign RD_DATA            = r.rd;
  assign LINK.sclk          = r.sclk;
  assign LINK.chip_select_n = r.cs_n;
  assign LINK.host_sd_o     = r.sd_o;
  assign LINK.host_sd_oe_n  = r.sd_oe_n;
endmodule // scr_host

//--- tb/scr_link_properties.sv
`timescale 1ns/1ps
module scr_link_properties (
  // System
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic BUS_VARIANT_SELECT_PIN,
  // Link
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic dev_sd_o,
  input wire logic dev_sd_oe_n,
  input wire logic dev_sdo_o,
  input wire logic dev_sdo_oe_n,
  input wire logic serial_data_in
);
  logic       sclk_q;
  logic       sd_q;
  logic [5:0] rises_ff;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  // Serial clock rises since chip select fell or since the last start
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      sclk_q   <= 1'b0;
      sd_q     <= 1'b1;
      rises_ff <= 6'h00;
    end else begin
      sclk_q <= sclk;
      sd_q   <= serial_data_in;
      if ((BUS_VARIANT_SELECT_PIN && chip_select_n) ||
          (!BUS_VARIANT_SELECT_PIN && sclk && sclk_q && sd_q && !serial_data_in)) begin
        rises_ff <= 6'h00;
      end else if (sclk && !sclk_q) begin
        rises_ff <= rises_ff + 6'h01;
      end
    end
  end

  word_bits_a: assert property (BUS_VARIANT_SELECT_PIN && $rose(chip_select_n) |->
    rises_ff == 6'h10) else $error("three-wire word not sixteen clocks");
  // 27 frame clocks plus the one the stop needs
  frame_bits_a: assert property (!BUS_VARIANT_SELECT_PIN && sclk && sclk_q &&
    !sd_q && serial_data_in |-> rises_ff == 6'h1C) else $error("two-wire frame length wrong");
  start_hold_a: assert property (!BUS_VARIANT_SELECT_PIN && sclk && $past(sclk) &&
    $fell(serial_data_in) |-> ##[1:24] !sclk) else $error("start not followed by clock");
  sdo_release_a: assert property ((BUS_VARIANT_SELECT_PIN && chip_select_n)[*5]
    |-> dev_sdo_oe_n) else $error("readback output driven with chip select high");
  sdo_in_frame_a: assert property ($fell(dev_sdo_oe_n) && BUS_VARIANT_SELECT_PIN
    |-> !chip_select_n) else $error("readback output enabled outside frame");
  sdo_window_a: assert property ($fell(dev_sdo_oe_n) |-> (!dev_sdo_oe_n)[*8])
    else $error("readback window too short");
  sdo_steady_a: assert property (!dev_sdo_oe_n && $past(!dev_sdo_oe_n) &&
    $changed(dev_sdo_o) |-> !sclk) else $error("readback bit changed while clock high");
  ack_drive_a: assert property (!dev_sd_oe_n |-> !dev_sd_o && !BUS_VARIANT_SELECT_PIN)
    else $error("acknowledge not an open-drain low");
  ack_edges_a: assert property ($changed(dev_sd_oe_n) |-> !sclk)
    else $error("acknowledge moved while clock high");
  ack_held_a: assert property ($rose(sclk) && !dev_sd_oe_n |-> (!dev_sd_oe_n)[*8])
    else $error("acknowledge dropped during clock high");
endmodule // scr_link_properties

//--- tb/tb.sv
`timescale 1ns/1ps
module tb import scr_pkg::*;;
  typedef struct packed {
    logic       tw;
    logic       asel;
    logic [6:0] addr;
    logic [8:0] data;
    logic [7:0] rd;
  } scr_row_t;

  logic        clk_sys, rst_b, hw_mode, bus_variant, two_wire, addr_sel, cmd_valid;
  logic [6:0]  cmd_addr, wr_addr;
  logic [8:0]  cmd_data, wr_data, rb_ctl, rb_exp;
  logic        cmd_ready, done, nack, wr_stb;
  logic [7:0]  rd_data;
  logic [55:0] status;
  int          fail_count, total_checks, wr_count, n0;
  // Two-wire rows end with address select high, so the wire idles high
  scr_row_t rows[12] = '{
    '{1'b0, 1'b0, 7'h05, 9'h1A5, 8'hFF}, '{1'b0, 1'b0, 7'h34, 9'h01B, 8'hFF},
    '{1'b0, 1'b0, 7'h7F, 9'h000, 8'h3C}, '{1'b0, 1'b0, 7'h34, 9'h010, 8'h3C},
    '{1'b0, 1'b0, 7'h3A, 9'h155, 8'hC3}, '{1'b0, 1'b0, 7'h3E, 9'h0AA, 8'hE7},
    '{1'b0, 1'b0, 7'h34, 9'h00E, 8'h00}, '{1'b0, 1'b0, 7'h12, 9'h0C3, 8'hFF},
    '{1'b1, 1'b0, 7'h34, 9'h01E, 8'hFF}, '{1'b1, 1'b1, 7'h20, 9'h1FF, 8'hE7},
    '{1'b1, 1'b0, 7'h34, 9'h017, 8'hE7}, '{1'b1, 1'b1, 7'h39, 9'h100, 8'h5A}};

  scr_link_if scr_link_if_i ();
  scr_host scr_host_i (.CLK_SYS(clk_sys), .RST_B(rst_b), .TWO_WIRE_SEL(two_wire),
    .ADDR_SEL(addr_sel), .CMD_VALID(cmd_valid), .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data),
    .CMD_READY(cmd_ready), .DONE(done), .NACK(nack), .RD_DATA(rd_data), .LINK(scr_link_if_i));
  scr_device scr_device_i (.CLK_SYS(clk_sys), .RST_B(rst_b),
    .CONTROL_MODE_SELECT_PIN(hw_mode), .BUS_VARIANT_SELECT_PIN(bus_variant),
    .STATUS_BYTES(status), .REG_WR_STB(wr_stb), .REG_WR_ADDR(wr_addr), .REG_WR_DATA(wr_data),
    .READBACK_CONTROL(rb_ctl), .LINK(scr_link_if_i));
  scr_link_properties scr_link_properties_i (.CLK_SYS(clk_sys), .RST_B(rst_b),
    .BUS_VARIANT_SELECT_PIN(bus_variant), .sclk(scr_link_if_i.sclk),
    .chip_select_n(scr_link_if_i.chip_select_n), .dev_sd_o(scr_link_if_i.dev_sd_o),
    .dev_sd_oe_n(scr_link_if_i.dev_sd_oe_n), .dev_sdo_o(scr_link_if_i.dev_sdo_o),
    .dev_sdo_oe_n(scr_link_if_i.dev_sdo_oe_n), .serial_data_in(scr_link_if_i.serial_data_in));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (wr_stb === 1'b1) begin
      wr_count <= wr_count + 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Pins pass a two-stage synchroniser, so settle before the command
  task automatic run_cmd(input logic tw, input logic asel, input logic [6:0] a,
                         input logic [8:0] d);
    int n;
    two_wire    <= tw;
    bus_variant <= ~tw;
    addr_sel    <= asel;
    repeat (4) @(posedge clk_sys);
    cmd_addr  <= a;
    cmd_data  <= d;
    cmd_valid <= 1'b1;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 1200) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 1200) begin
      fail_count++;
      complete_run();
    end
    repeat (8) @(posedge clk_sys);
  endtask

  initial begin
    rst_b = 1'b0;
    hw_mode = 1'b0;
    bus_variant = 1'b1;
    two_wire = 1'b0;
    addr_sel = 1'b0;
    cmd_valid = 1'b0;
    cmd_addr = 7'h00;
    cmd_data = 9'h000;
    status = 56'hE77E813CC35A96;
    rb_exp = 9'h000;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    check(rb_ctl, 9'h000);
    check(scr_link_if_i.serial_data_out, 1'b1);
    $display("reset test done");
    foreach (rows[i]) begin
      n0 = wr_count;
      run_cmd(rows[i].tw, rows[i].asel, rows[i].addr, rows[i].data);
      if (rows[i].addr == 7'h34) rb_exp = rows[i].data;
      check(rd_data, rows[i].rd);
      check(nack, 1'b0);
      check(wr_count, n0 + 1);
      check({wr_addr, wr_data}, {rows[i].addr, rows[i].data});
      check(rb_ctl, rb_exp);
    end
    $display("table test done");
    for (int k = 0; k < 8; k++) begin
      run_cmd(1'b0, 1'b1, 7'h34, 9'h018 | 9'(k));
      run_cmd(1'b0, 1'b1, 7'h01, 9'h000);
      check(rd_data, (k < 7) ? status[8*k +: 8] : 8'h00);
    end
    $display("select test done");
    hw_mode <= 1'b1;
    n0 = wr_count;
    run_cmd(1'b0, 1'b0, 7'h05, 9'h055);
    check(wr_count, n0);
    check(rd_data, 8'hFF);
    hw_mode <= 1'b0;
    $display("hardware mode test done");
    // Strap flipped mid-frame cuts the word; two-wire first, address select high
    for (int m = 1; m >= 0; m--) begin
      n0 = wr_count;
      fork
        run_cmd(m[0], m[0], 7'h05, 9'h0AA);
        begin
          repeat (100) @(posedge clk_sys);
          hw_mode <= 1'b1;
          repeat (40) @(posedge clk_sys);
          hw_mode <= 1'b0;
        end
      join
      check(wr_count, n0);
      check(nack, m[0]);
    end
    $display("cut frame test done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(rb_ctl, 9'h000);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    run_cmd(1'b0, 1'b0, 7'h7F, 9'h000);
    check(rd_data, 8'hFF);
    $display("second reset test done");
    complete_run();
  end
endmodule // tb
